// ### hdl/fep_pkg.sv
package fep_pkg;
	// ****************************************
	// register numbering
	// ****************************************
	localparam int REG_W = 16;
	localparam int REGNUM_W = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_LPA = 5'h05;
	localparam logic [4:0] REG_DRV = 5'h1a;
	localparam logic [4:0] REG_TXC = 5'h1e;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_RESET = 15;
	localparam int CTRL_SPEED = 13;
	localparam int CTRL_ANEN = 12;
	localparam int CTRL_PDOWN = 11;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_DUPLEX = 8;
	localparam int STAT_ANDONE = 5;
	localparam int STAT_RFAULT = 4;
	localparam int STAT_LINK = 2;
	localparam int ADV_RFAULT = 13;
	localparam int ADV_100FD = 8;
	localparam int ADV_100HD = 7;
	localparam int ADV_10FD = 6;
	localparam int ADV_10HD = 5;
	localparam int DRV_STRONG = 11;
	localparam int TXC_SLEW_LO = 10;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] CTRL_RST = 16'h3100;
	localparam logic [15:0] STAT_FIXED = 16'h7809;
	localparam logic [15:0] ADV_RST = 16'h01e1;
	localparam logic [15:0] DRV_RST = 16'h0000;
	localparam logic [15:0] TXC_RST = 16'h0000;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_KHZ = 25000;
	localparam int NIB10_KHZ = 2500;
	localparam int NIB10_DIV = CLK_KHZ / NIB10_KHZ;
	localparam int NLP_INTERVAL_MS = 16;
	localparam int NLP_CYCLES = NLP_INTERVAL_MS * CLK_KHZ;
	// ****************************************
	// controller local register space
	// ****************************************
	localparam int HADDR_W = 6;
	localparam int HADDR_LOCAL = 5;
	localparam logic [5:0] HREG_LINK = 6'h20;
	localparam int HLINK_UP = 0;
	localparam int HLINK_SPEED = 1;
	localparam int HLINK_FULL = 2;
	localparam int HLINK_DRIVE = 3;
	// ****************************************
	// line symbol kinds
	// ****************************************
	typedef enum logic [1:0] {SYM_SILENT, SYM_IDLE, SYM_DATA, SYM_FLP} fep_sym_t;
endpackage

// ### hdl/fep_if.sv
`timescale 1ns/1ps
interface fep_if;
	logic tx_clk_en;
	logic tx_en;
	logic [3:0] txd;
	logic rx_dv;
	logic [3:0] rxd;
	logic rx_er;
	logic col;
	logic crs;
	logic drive_hi;
	logic link_up;
	logic speed100;
	logic full_dup;
	logic mgmt_req;
	logic mgmt_we;
	logic [4:0] mgmt_reg;
	logic [15:0] mgmt_wdata;
	logic [15:0] mgmt_rdata;
	modport phy(
		output tx_clk_en, rx_dv, rxd, rx_er, col, crs, drive_hi, link_up, speed100, full_dup,
		output mgmt_rdata,
		input tx_en, txd, mgmt_req, mgmt_we, mgmt_reg, mgmt_wdata
	);
	modport mac(
		input tx_clk_en, rx_dv, rxd, rx_er, col, crs, drive_hi, link_up, speed100, full_dup,
		input mgmt_rdata,
		output tx_en, txd, mgmt_req, mgmt_we, mgmt_reg, mgmt_wdata
	);
endinterface

// ### hdl/fep_buf2.sv
`timescale 1ns/1ps
module fep_buf2 #(
	parameter int W = 4,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	initial begin
		if (DEPTH != 2 || W < 1) begin
			$error("fep_buf2: only two entries of nonzero width are served");
		end
	end
	logic [W-1:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic push;
	logic pop;
	assign in_ready = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ### hdl/fep_mac_end.sv
`timescale 1ns/1ps
module fep_mac_end (
	input wire logic clk,
	input wire logic sys_rst,
	fep_if.mac link,
	input wire logic [fep_pkg::HADDR_W-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic tx_valid,
	input wire logic [3:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [3:0] rx_data,
	output logic rx_err
);
	import fep_pkg::*;
	// ****************************************
	// management forwarding
	// ****************************************
	logic local_sel_reg;
	logic [15:0] local_rdata_reg;
	assign link.mgmt_req = (wr || rd) && !addr[HADDR_LOCAL];
	assign link.mgmt_we = wr;
	assign link.mgmt_reg = addr[REGNUM_W-1:0];
	assign link.mgmt_wdata = wdata;
	assign rdata = local_sel_reg ? local_rdata_reg : link.mgmt_rdata;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			local_sel_reg <= 1'b0;
			local_rdata_reg <= 16'h0000;
		end else begin
			local_sel_reg <= addr[HADDR_LOCAL];
			local_rdata_reg <= 16'h0000;
			if (rd && addr == HREG_LINK) begin
				local_rdata_reg[HLINK_UP] <= link.link_up;
				local_rdata_reg[HLINK_SPEED] <= link.speed100;
				local_rdata_reg[HLINK_FULL] <= link.full_dup;
				local_rdata_reg[HLINK_DRIVE] <= link.drive_hi;
			end
		end
	end
	// ****************************************
	// transmit path
	// ****************************************
	logic buf_valid;
	logic [3:0] buf_data;
	logic drain;
	assign drain = link.tx_clk_en && link.link_up;
	fep_buf2 #(.W(4), .DEPTH(2)) u_txbuf (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(tx_valid),
		.in_data(tx_data),
		.in_ready(tx_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(drain)
	);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.tx_en <= 1'b0;
			link.txd <= 4'h0;
		end else if (link.tx_clk_en) begin
			link.tx_en <= buf_valid && link.link_up;
			link.txd <= buf_data;
		end
	end
	// ****************************************
	// receive path
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_data <= 4'h0;
			rx_err <= 1'b0;
		end else begin
			rx_valid <= link.tx_clk_en && link.rx_dv;
			if (link.tx_clk_en) begin
				rx_data <= link.rxd;
				rx_err <= link.rx_er;
			end
		end
	end
endmodule

// ### hdl/fep_phy_end.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module fep_phy_end #(
	parameter int NLP_GAP = fep_pkg::NLP_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	fep_if.phy link,
	input wire logic line_link_ok,
	input wire logic line_nlp_seen,
	input wire logic line_idle_seen,
	input wire logic line_flp_valid,
	input wire logic [15:0] line_flp_word,
	input wire logic line_rx_valid,
	input wire logic [3:0] line_rx_nibble,
	input wire logic line_rx_err,
	output fep_pkg::fep_sym_t line_tx_kind,
	output logic [3:0] line_tx_nibble,
	output logic [15:0] line_tx_word,
	output logic line_nlp_pulse,
	output logic [1:0] line_slew
);
	import fep_pkg::*;
	initial begin
		if (NLP_GAP < 2) begin
			$error("fep_phy_end: link pulse gap too short");
		end
	end
	typedef enum logic [1:0] {LS_DOWN, LS_NEG, LS_UP} fep_link_t;
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] flt_reg;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
			flt_reg <= 3'h0;
		end else begin
			s1_reg <= {line_idle_seen, line_nlp_seen, line_link_ok};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < 3; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					flt_reg[i] <= s3_reg[i];
				end
			end
		end
	end
	// ****************************************
	// management registers
	// ****************************************
	logic [15:0] ctrl_reg;
	logic [15:0] adv_reg;
	logic [15:0] lpa_reg;
	logic [15:0] drv_reg;
	logic [15:0] txc_reg;
	logic stat_rf_reg;
	fep_link_t state_reg;
	logic speed_reg;
	logic full_reg;
	logic an_done_reg;
	logic wr_hit;
	logic rd_hit;
	logic [15:0] stat_val;
	assign wr_hit = link.mgmt_req && link.mgmt_we;
	assign rd_hit = link.mgmt_req && !link.mgmt_we;
	always_comb begin
		stat_val = STAT_FIXED;
		stat_val[STAT_RFAULT] = stat_rf_reg;
		stat_val[STAT_LINK] = (state_reg == LS_UP);
		stat_val[STAT_ANDONE] = an_done_reg;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.mgmt_rdata <= 16'h0000;
		end else if (rd_hit) begin
			case (link.mgmt_reg)
				REG_CTRL: link.mgmt_rdata <= ctrl_reg;
				REG_STAT: link.mgmt_rdata <= stat_val;
				REG_ADV: link.mgmt_rdata <= adv_reg;
				REG_LPA: link.mgmt_rdata <= lpa_reg;
				REG_DRV: link.mgmt_rdata <= drv_reg;
				REG_TXC: link.mgmt_rdata <= txc_reg;
				default: link.mgmt_rdata <= 16'h0000;
			endcase
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RST;
			adv_reg <= ADV_RST;
			drv_reg <= DRV_RST;
			txc_reg <= TXC_RST;
		end else if (ctrl_reg[CTRL_RESET]) begin
			ctrl_reg <= CTRL_RST;
			adv_reg <= ADV_RST;
			drv_reg <= DRV_RST;
			txc_reg <= TXC_RST;
		end else begin
			if (state_reg == LS_NEG) begin
				ctrl_reg[CTRL_RESTART] <= 1'b0;
			end
			if (wr_hit) begin
				case (link.mgmt_reg)
					REG_CTRL: ctrl_reg <= link.mgmt_wdata;
					REG_ADV: adv_reg <= link.mgmt_wdata;
					REG_DRV: drv_reg <= link.mgmt_wdata;
					REG_TXC: txc_reg <= link.mgmt_wdata;
					default: ;
				endcase
			end
		end
	end
	// ****************************************
	// remote fault capture
	// ****************************************
	logic flp_take;
	logic rf_in;
	assign flp_take = (state_reg == LS_NEG) && line_flp_valid;
	assign rf_in = flp_take && line_flp_word[ADV_RFAULT];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_rf_reg <= 1'b0;
			lpa_reg <= 16'h0000;
		end else begin
			if (rf_in) begin
				stat_rf_reg <= 1'b1;
			end else if (rd_hit && link.mgmt_reg == REG_STAT) begin
				stat_rf_reg <= 1'b0;
			end
			if (flp_take) begin
				lpa_reg <= line_flp_word;
				lpa_reg[ADV_RFAULT] <= line_flp_word[ADV_RFAULT] | lpa_reg[ADV_RFAULT];
			end else if (rd_hit && link.mgmt_reg == REG_LPA) begin
				lpa_reg[ADV_RFAULT] <= 1'b0;
			end
		end
	end
	// ****************************************
	// link resolution
	// ****************************************
	logic [15:0] common;
	assign common = adv_reg & line_flp_word;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= LS_DOWN;
			speed_reg <= 1'b0;
			full_reg <= 1'b0;
			an_done_reg <= 1'b0;
		end else begin
			case (state_reg)
				LS_DOWN: begin
					an_done_reg <= 1'b0;
					if (ctrl_reg[CTRL_PDOWN] || ctrl_reg[CTRL_RESET]) begin
						state_reg <= LS_DOWN;
					end else if (!ctrl_reg[CTRL_ANEN]) begin
						speed_reg <= ctrl_reg[CTRL_SPEED];
						full_reg <= ctrl_reg[CTRL_DUPLEX];
						if (flt_reg[0]) begin
							state_reg <= LS_UP;
						end
					end else begin
						state_reg <= LS_NEG;
					end
				end
				LS_NEG: begin
					if (flp_take && (common[ADV_100FD:ADV_10HD] != 4'h0)) begin
						speed_reg <= common[ADV_100FD] || common[ADV_100HD];
						full_reg <= common[ADV_100FD] ||
							(!common[ADV_100HD] && common[ADV_10FD]);
						an_done_reg <= 1'b1;
						state_reg <= LS_UP;
					end else if (flt_reg[1]) begin
						speed_reg <= 1'b0;
						full_reg <= 1'b0;
						state_reg <= LS_UP;
					end else if (flt_reg[2]) begin
						speed_reg <= 1'b1;
						full_reg <= 1'b0;
						state_reg <= LS_UP;
					end
				end
				LS_UP: begin
					if (!flt_reg[0] || ctrl_reg[CTRL_RESTART] || ctrl_reg[CTRL_PDOWN]
						|| ctrl_reg[CTRL_RESET]) begin
						state_reg <= LS_DOWN;
					end
				end
				default: state_reg <= LS_DOWN;
			endcase
		end
	end
	// ****************************************
	// nibble rate and link pulses
	// ****************************************
	logic [3:0] div_reg;
	logic [$clog2(NLP_GAP)-1:0] nlp_cnt_reg;
	logic up;
	assign up = (state_reg == LS_UP);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_reg <= 4'h0;
			link.tx_clk_en <= 1'b0;
		end else begin
			if (speed_reg || div_reg == 4'(NIB10_DIV - 1)) begin
				div_reg <= 4'h0;
			end else begin
				div_reg <= div_reg + 4'h1;
			end
			link.tx_clk_en <= speed_reg || div_reg == 4'(NIB10_DIV - 1);
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nlp_cnt_reg <= '0;
			line_nlp_pulse <= 1'b0;
		end else begin
			line_nlp_pulse <= 1'b0;
			if (!up || speed_reg || link.tx_en) begin
				nlp_cnt_reg <= '0;
			end else if (nlp_cnt_reg == ($clog2(NLP_GAP))'(NLP_GAP - 1)) begin
				nlp_cnt_reg <= '0;
				line_nlp_pulse <= 1'b1;
			end else begin
				nlp_cnt_reg <= nlp_cnt_reg + 1'b1;
			end
		end
	end
	// ****************************************
	// data paths
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_tx_kind <= SYM_SILENT;
			line_tx_nibble <= 4'h0;
			link.rx_dv <= 1'b0;
			link.rxd <= 4'h0;
			link.rx_er <= 1'b0;
		end else if (state_reg == LS_NEG) begin
			line_tx_kind <= SYM_FLP;
		end else if (!up) begin
			line_tx_kind <= SYM_SILENT;
		end else if (link.tx_clk_en) begin
			line_tx_nibble <= link.txd;
			if (link.tx_en) begin
				line_tx_kind <= SYM_DATA;
			end else if (speed_reg) begin
				line_tx_kind <= SYM_IDLE;
			end else begin
				line_tx_kind <= SYM_SILENT;
			end
			link.rx_dv <= line_rx_valid;
			link.rxd <= line_rx_nibble;
			link.rx_er <= line_rx_err;
		end
	end
	assign line_tx_word = adv_reg;
	assign line_slew = txc_reg[TXC_SLEW_LO+1:TXC_SLEW_LO];
	assign link.crs = up && (link.rx_dv || (!full_reg && link.tx_en));
	assign link.col = up && !full_reg && link.tx_en && link.rx_dv;
	assign link.drive_hi = drv_reg[DRV_STRONG];
	assign link.link_up = up;
	assign link.speed100 = speed_reg;
	assign link.full_dup = full_reg;
endmodule

// ### test/fep_link_checker.sv
`timescale 1ns/1ps
// ****************************************
// interface checker
// ****************************************
module fep_link_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_clk_en,
	input wire logic drive_hi,
	input wire logic link_up,
	input wire logic speed100,
	input wire logic full_dup,
	input wire logic mgmt_req,
	input wire logic mgmt_we,
	input wire logic [4:0] mgmt_reg,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata
);
	import fep_pkg::*;
	logic fast;
	assign fast = link_up && speed100;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_wr(r);
		mgmt_req && mgmt_we && mgmt_reg == r;
	endsequence
	sequence s_rd(r);
		mgmt_req && !mgmt_we && mgmt_reg == r;
	endsequence
	AST_CLK_FAST: assert property (fast && $past(fast, 2) |-> tx_clk_en)
		else $error("nibble strobe missing at 100M");
	AST_CLK_SLOW: assert property (tx_clk_en && link_up && !speed100 |=> (!tx_clk_en || speed100) [*8])
		else $error("nibble strobe too often at 10M");
	AST_DRV_SET: assert property (s_wr(REG_DRV) |=> drive_hi == $past(mgmt_wdata[DRV_STRONG]))
		else $error("drive strength not following register");
	AST_DRV_READ: assert property (s_rd(REG_DRV) |=> mgmt_rdata[DRV_STRONG] == $past(drive_hi))
		else $error("drive bit read back wrong");
	AST_STAT_FIXED: assert property (s_rd(REG_STAT) |=> (mgmt_rdata & STAT_FIXED) == STAT_FIXED)
		else $error("status fixed bits wrong");
	AST_ADV_BACK: assert property (s_wr(REG_ADV) ##1 s_rd(REG_ADV)
		|=> mgmt_rdata[ADV_RFAULT] == $past(mgmt_wdata[ADV_RFAULT], 2))
		else $error("fault advert bit lost");
	AST_SPEED_HOLD: assert property (link_up && $past(link_up) |-> $stable(speed100) && $stable(full_dup))
		else $error("mode changed while link up");
	AST_RESTART: assert property (s_wr(REG_CTRL) ##0 mgmt_wdata[CTRL_RESTART] |-> ##[1:3] !link_up)
		else $error("restart did not drop link");
endmodule

// ### test/fast_ethernet_phy_link_core_test.sv
`timescale 1ns/1ps
module fast_ethernet_phy_link_core_test;
	import fep_pkg::*;
	logic clk, sys_rst, ok, nlp, idl, flp_v, rx_v, rx_e, wr, rd, tx_v;
	logic tx_rdy, rx_vo, rx_eo, nlp_p;
	logic [15:0] flp_w, wdata, rdata, tx_word, rv;
	logic [5:0] addr;
	logic [3:0] rx_n, tx_d, rx_d, tx_n;
	logic [1:0] slew;
	fep_sym_t kind;
	int err_count, cmp_count, cyc, npul;
	logic [4:0] txq[$], rxq[$];
	logic [5:0] ra[7] = '{6'h00, 6'h04, 6'h1a, 6'h1e, 6'h01, 6'h20, 6'h3f};
	logic [15:0] re[7] = '{CTRL_RST, ADV_RST, DRV_RST, TXC_RST, STAT_FIXED, 16'h0, 16'h0};
	logic [15:0] pw[4] = '{16'h0100, 16'h0080, 16'h0040, 16'h2020};
	logic [3:0] pe[4] = '{4'h7, 4'h3, 4'h5, 4'h1};
	logic [4:0] txe[3] = '{5'h05, 5'h0a, 5'h0c};
	logic [4:0] rxe[2] = '{5'h05, 5'h1a};
	// ****************************************
	// both ends and checker
	// ****************************************
	fep_if u_fep_if();
	fep_phy_end #(.NLP_GAP(20)) u_fep_phy_end(.clk(clk), .sys_rst(sys_rst), .link(u_fep_if.phy),
		.line_link_ok(ok), .line_nlp_seen(nlp), .line_idle_seen(idl), .line_flp_valid(flp_v),
		.line_flp_word(flp_w), .line_rx_valid(rx_v), .line_rx_nibble(rx_n), .line_rx_err(rx_e),
		.line_tx_kind(kind), .line_tx_nibble(tx_n), .line_tx_word(tx_word),
		.line_nlp_pulse(nlp_p), .line_slew(slew));
	fep_mac_end u_fep_mac_end(.clk(clk), .sys_rst(sys_rst), .link(u_fep_if.mac), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_valid(tx_v), .tx_data(tx_d),
		.tx_ready(tx_rdy), .rx_valid(rx_vo), .rx_data(rx_d), .rx_err(rx_eo));
	fep_link_checker u_fep_link_checker(.clk(clk), .sys_rst(sys_rst),
		.tx_clk_en(u_fep_if.tx_clk_en), .drive_hi(u_fep_if.drive_hi),
		.link_up(u_fep_if.link_up), .speed100(u_fep_if.speed100), .full_dup(u_fep_if.full_dup),
		.mgmt_req(u_fep_if.mgmt_req), .mgmt_we(u_fep_if.mgmt_we), .mgmt_reg(u_fep_if.mgmt_reg),
		.mgmt_wdata(u_fep_if.mgmt_wdata), .mgmt_rdata(u_fep_if.mgmt_rdata));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// optional write, then read back
	task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		if (w) begin
			@(posedge clk);
			wr <= 1'b0;
			rd <= 1'b1;
		end
		@(posedge clk);
		rd <= 1'b0;
		// local read data stand only in this cycle; take them mid-cycle
		@(negedge clk);
		rv = rdata;
	endtask
	task automatic wait_up(input logic [3:0] exp);
		rv = '0;
		for (int i = 0; i < 30 && rv[0] !== 1'b1; i++)
			acc(1'b0, 6'h20, 16'h0);
		chk(rv, {12'h0, exp});
	endtask
	task automatic neg(input logic [15:0] w, input logic [3:0] exp);
		acc(1'b1, 6'h00, 16'h1200);
		@(posedge clk);
		flp_w <= w;
		flp_v <= w != 16'h0;
		@(posedge clk);
		flp_v <= 1'b0;
		wait_up(exp);
	endtask
	// hold valid until the edge at which ready is high
	task automatic take();
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			if (tx_rdy === 1'b1)
				break;
		end
		@(posedge clk);
		tx_v <= 1'b0;
	endtask
	task automatic push(input logic [3:0] d);
		@(posedge clk);
		tx_v <= 1'b1;
		tx_d <= d;
		take();
	endtask
	// ****************************************
	// clock, monitors, timeout
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge clk) begin
		cyc++;
		if (nlp_p === 1'b1)
			npul++;
		if (kind === SYM_DATA)
			txq.push_back({1'b0, tx_n});
		if (rx_vo === 1'b1)
			rxq.push_back({rx_eo, rx_d});
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		{ok, nlp, idl, flp_v, rx_v, rx_e, wr, rd, tx_v} = '0;
		{flp_w, wdata, rv, addr, rx_n, tx_d} = '0;
		{err_count, cmp_count, cyc, npul} = '0;
		sys_rst = 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (ra[i]) begin
			acc(1'b0, ra[i], 16'h0);
			chk(ra[i] == 6'h01 ? rv & STAT_FIXED : rv, re[i]);
		end
		acc(1'b1, 6'h3f, 16'hffff);
		chk(rv, 16'h0);
		$display("test reset values done");
		acc(1'b1, 6'h1a, 16'h0800);
		chk({15'h0, u_fep_if.drive_hi}, 16'h1);
		acc(1'b0, 6'h20, 16'h0);
		chk(rv, 16'h0008);
		acc(1'b1, 6'h1a, 16'h0);
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, 6'h1e, 16'(s) << TXC_SLEW_LO);
			chk({14'h0, slew}, 16'(s));
		end
		acc(1'b1, 6'h04, 16'h21e1);
		chk(tx_word, 16'h21e1);
		acc(1'b1, 6'h04, ADV_RST);
		$display("test control bits done");
		ok <= 1'b1;
		foreach (pw[i])
			neg(pw[i], pe[i]);
		acc(1'b0, 6'h01, 16'h0);
		chk(rv & 16'h0030, 16'h0030);
		acc(1'b0, 6'h01, 16'h0);
		chk(rv & 16'h0010, 16'h0);
		acc(1'b0, 6'h05, 16'h0);
		chk(rv & 16'h2000, 16'h2000);
		acc(1'b0, 6'h05, 16'h0);
		chk(rv & 16'h2000, 16'h0);
		npul = 0;
		repeat (70) @(posedge clk);
		chk(16'(npul >= 3 && npul <= 4), 16'h1);
		chk(16'(kind), 16'(SYM_SILENT));
		$display("test negotiation done");
		nlp <= 1'b1;
		neg(16'h0, 4'h1);
		nlp <= 1'b0;
		repeat (6) @(posedge clk);
		idl <= 1'b1;
		neg(16'h0, 4'h3);
		idl <= 1'b0;
		chk(16'(kind), 16'(SYM_IDLE));
		$display("test parallel detection done");
		acc(1'b1, 6'h00, 16'h1200);
		txq = {};
		push(4'h5);
		push(4'ha);
		@(posedge clk);
		tx_v <= 1'b1;
		tx_d <= 4'hc;
		repeat (3) @(posedge clk);
		chk({15'h0, tx_rdy}, 16'h0);
		flp_w <= 16'h0100;
		flp_v <= 1'b1;
		@(posedge clk);
		flp_v <= 1'b0;
		take();
		repeat (20) @(posedge clk);
		chk(16'(txq.size()), 16'h3);
		foreach (txe[i])
			chk({11'h0, txq[i]}, {11'h0, txe[i]});
		rxq = {};
		@(posedge clk);
		rx_v <= 1'b1;
		rx_n <= 4'h5;
		@(posedge clk);
		rx_n <= 4'ha;
		rx_e <= 1'b1;
		@(posedge clk);
		rx_v <= 1'b0;
		rx_e <= 1'b0;
		repeat (10) @(posedge clk);
		chk(16'(rxq.size()), 16'h2);
		foreach (rxe[i])
			chk({11'h0, rxq[i]}, {11'h0, rxe[i]});
		$display("test data path done");
		close_out();
	end
endmodule
